//--- logic/fw_cmd_consts.svh
/*
  Named constants for the firmware copy and run command handling:
  command codes, request field values, status codes, timing.
  Assumes inclusion by bare name from the device and host design files.
*/
`ifndef FW_CMD_CONSTS_SVH
`define FW_CMD_CONSTS_SVH

// command codes and request layout
`define CODE_COPY 16'h0108
`define CODE_RUN 16'h0109
`define LPL_COPY 8'h01
`define LPL_RUN 8'h04
`define WAY_A_TO_B 8'hab
`define WAY_B_TO_A 8'hba
`define TARGET_MAX 8'h03
`define REPLY_LEN_COPY 8'h06
`define REPLY_LEN_RUN 8'h00
`define COPY_OK 8'h00
`define COPY_BAD 8'h01
// status codes
`define ST_IDLE 8'h00
`define ST_CAPTURED 8'h81
`define ST_CHECKING 8'h82
`define ST_EXECUTING 8'h83
`define ST_SUCCESS 8'h01
`define ST_FAIL 8'h40
`define ST_RANGE 8'h42
`define ST_CHK 8'h45
// timing: one millisecond at 50 MHz
`define CLK_MHZ 50
`define MS_CYCLES (`CLK_MHZ * 1000)

`endif

//--- logic/fw_cmd_pkg.sv
/*
  Types shared by both ends of the firmware command link.
  Assumes fw_cmd_consts.svh is on the include path.
*/
package fw_cmd_pkg;
  // one request as the host writes it into the command buffer
  typedef struct packed {
    logic [15:0] command_code;
    logic [15:0] extended_payload_length;
    logic [7:0] local_payload_length;
    logic [7:0] request_check_code;
    logic [7:0] reply_length;
    logic [7:0] reply_check_code;
    logic [7:0] byte136;
    logic [7:0] byte137;
    logic [15:0] byte138_139;
  } request_t;

  // reply fields the device writes back
  typedef struct packed {
    logic [7:0] reply_length;
    logic [7:0] reply_check_code;
    logic [31:0] bytes_copied;
    logic [7:0] copy_way;
    logic [7:0] copy_outcome;
  } reply_t;

  // device phases, one-hot
  typedef enum logic [5:0] {
    DEV_IDLE = 6'h01,
    DEV_CAPTURE = 6'h02,
    DEV_CHECK = 6'h04,
    DEV_EXEC = 6'h08,
    DEV_DELAY = 6'h10,
    DEV_DONE = 6'h20
  } dev_state_t;

  // host phases, one-hot
  typedef enum logic [2:0] {
    HOST_IDLE = 3'h1,
    HOST_SEND = 3'h2,
    HOST_WAIT = 3'h4
  } host_state_t;

  // check code over the header bytes 128..132, plus byte 136 when there is any local payload and bytes 137..139 when it exceeds one byte
  function automatic logic [7:0] check_code(input request_t r);
    logic [7:0] s;
    s = r.command_code[15:8] + r.command_code[7:0]
      + r.extended_payload_length[15:8]
      + r.extended_payload_length[7:0] + r.local_payload_length;
    if (r.local_payload_length != 8'h00) begin
      s = s + r.byte136;
    end
    if (r.local_payload_length > 8'h01) begin
      s = s + r.byte137 + r.byte138_139[15:8] + r.byte138_139[7:0];
    end
    return ~s;
  endfunction
endpackage

//--- logic/fw_cmd_if.sv
/*
  Link between the host controller and the module command engine.
  Models the command buffer write and the status page as plain signals;
  the two-wire bus itself lies outside.
*/
`timescale 1ns/10ps
interface fw_cmd_if;
  logic req_valid;
  fw_cmd_pkg::request_t req;
  logic busy;
  logic command_done_flag;
  logic [7:0] command_result_code;
  fw_cmd_pkg::reply_t reply;

  modport device (
    input req_valid, req,
    output busy, command_done_flag, command_result_code, reply
  );
  modport host (
    output req_valid, req,
    input busy, command_done_flag, command_result_code, reply
  );
endinterface // fw_cmd_if

//--- logic/fw_cmd_device.sv
/*
  Module-side engine for the copy-image and run-image commands.
  Assumes the host holds each request stable while req_valid is high and
  a flash copier answers copy_start with copy_done within bounded time.
*/
// How it works
// - copy request: code 0108h, payload one byte
// - byte 136 picks copy way ABh/BAh
// - copy reply length 6, bytes copied
// - echo performed copy way in reply
// - copy outcome 00h good, 01h bad
// - byte 137 picks reset target 0-3
// - reset waits delay ms after done flag
// - host expects early reset at zero delay
// - run time bounded by ordinary reboot time
// - done flag set when either command ends
// - busy phases captured, checking, executing shown
// - final status codes success or failure kinds
// - request check code verified by device
// - host may prefill reply length, check code
// - copy support optional, parameter enables it
`timescale 1ns/10ps
`include "fw_cmd_consts.svh"
module fw_cmd_device #(
  parameter bit COPY_SUPPORTED = 1'b1,
  parameter int DELAY_UNIT = `MS_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // link to host
  fw_cmd_if.device link,
  // flash copier
  output logic copy_start,
  output logic [7:0] copy_way_out,
  input wire logic copy_done,
  input wire logic copy_fail,
  input wire logic [31:0] copy_count,
  // image reset request
  output logic reset_pulse,
  output logic [1:0] reset_target
);
  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  // a unit below one would wrap the tick limit and stretch each delay step to billions of cycles
  if (DELAY_UNIT < 1) begin : g_bad_unit
    $error("DELAY_UNIT must be positive");
  end

  typedef struct packed {
    fw_cmd_pkg::dev_state_t st;
    fw_cmd_pkg::request_t req;
    logic is_run;
    logic [7:0] result;
    logic done;
    logic start;
    logic rst;
    logic [1:0] target;
    logic [15:0] ms_left;
    logic [31:0] tick;
    fw_cmd_pkg::reply_t reply;
  } dev_t;

  dev_t cur;
  dev_t next_cur;

  // ------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------
  // decode and sanity of a captured request; a bad check code is
  // reported before any field of the request is trusted
  function automatic logic [7:0] verdict(input fw_cmd_pkg::request_t r);
    logic cp;
    logic rn;
    cp = r.command_code == `CODE_COPY;
    rn = r.command_code == `CODE_RUN;
    if (fw_cmd_pkg::check_code(r) != r.request_check_code) begin
      return `ST_CHK;
    end
    if (cp && !COPY_SUPPORTED) begin
      return `ST_RANGE;
    end
    if (cp && (r.extended_payload_length == 16'h0000)
        && r.local_payload_length == `LPL_COPY
        && (r.byte136 == `WAY_A_TO_B || r.byte136 == `WAY_B_TO_A)) begin
      return `ST_EXECUTING;
    end
    if (rn && (r.extended_payload_length == 16'h0000)
        && r.local_payload_length == `LPL_RUN && r.byte136 == 8'h00
        && r.byte137 <= `TARGET_MAX) begin
      return `ST_EXECUTING;
    end
    return `ST_RANGE;
  endfunction

  // reply check code: inverted byte sum of the copy reply fields
  function automatic logic [7:0] reply_sum(input logic [31:0] n,
                                           input logic [7:0] way,
                                           input logic [7:0] outcome);
    logic [7:0] s;
    s = `REPLY_LEN_COPY + n[31:24] + n[23:16] + n[15:8] + n[7:0]
      + way + outcome;
    return ~s;
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] judged;
    judged = verdict(cur.req);
    next_cur = cur;
    next_cur.start = 1'b0;
    next_cur.rst = 1'b0;
    case (cur.st)
      fw_cmd_pkg::DEV_IDLE,
      fw_cmd_pkg::DEV_DONE: begin
        if (link.req_valid) begin
          next_cur.req = link.req;
          next_cur.done = 1'b0;
          next_cur.result = `ST_CAPTURED;
          next_cur.st = fw_cmd_pkg::DEV_CAPTURE;
        end
      end
      fw_cmd_pkg::DEV_CAPTURE: begin
        next_cur.result = `ST_CHECKING;
        next_cur.st = fw_cmd_pkg::DEV_CHECK;
      end
      fw_cmd_pkg::DEV_CHECK: begin
        next_cur.is_run = cur.req.command_code == `CODE_RUN;
        if (judged == `ST_EXECUTING) begin
          next_cur.result = `ST_EXECUTING;
          next_cur.st = fw_cmd_pkg::DEV_EXEC;
          next_cur.start = cur.req.command_code == `CODE_COPY;
        end else begin
          next_cur.result = judged;
          next_cur.done = 1'b1;
          next_cur.st = fw_cmd_pkg::DEV_DONE;
        end
      end
      fw_cmd_pkg::DEV_EXEC: begin
        if (cur.is_run) begin
          // run reports success first, then resets after the delay
          next_cur.result = `ST_SUCCESS;
          next_cur.reply.reply_length = `REPLY_LEN_RUN;
          next_cur.reply.reply_check_code = 8'hff;
          next_cur.done = 1'b1;
          next_cur.target = cur.req.byte137[1:0];
          next_cur.ms_left = cur.req.byte138_139;
          next_cur.tick = 32'h0000_0000;
          next_cur.st = fw_cmd_pkg::DEV_DELAY;
        end else if (copy_done) begin
          next_cur.reply.reply_length = `REPLY_LEN_COPY;
          next_cur.reply.bytes_copied = copy_count;
          next_cur.reply.copy_way = cur.req.byte136;
          next_cur.reply.copy_outcome =
            copy_fail ? `COPY_BAD : `COPY_OK;
          next_cur.reply.reply_check_code = reply_sum(copy_count,
            cur.req.byte136, copy_fail ? `COPY_BAD : `COPY_OK);
          next_cur.result = copy_fail ? `ST_FAIL : `ST_SUCCESS;
          next_cur.done = 1'b1;
          next_cur.st = fw_cmd_pkg::DEV_DONE;
        end
      end
      fw_cmd_pkg::DEV_DELAY: begin
        // counting from the done flag keeps the run bounded by the delay
        if (cur.ms_left == 16'h0000) begin
          next_cur.rst = 1'b1;
          next_cur.st = fw_cmd_pkg::DEV_IDLE;
        end else if (cur.tick == 32'(DELAY_UNIT - 1)) begin
          next_cur.tick = 32'h0000_0000;
          next_cur.ms_left = cur.ms_left - 16'h0001;
        end else begin
          next_cur.tick = cur.tick + 32'h0000_0001;
        end
      end
      default: begin
        next_cur.st = fw_cmd_pkg::DEV_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cur <= '0;
      cur.st <= fw_cmd_pkg::DEV_IDLE;
    end else if (clk_en) begin
      cur <= next_cur;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // busy drops in the reset delay so the host can read the result;
  // a request sent then is ignored, so the host must not send one
  assign link.busy = !(cur.st == fw_cmd_pkg::DEV_IDLE
                       || cur.st == fw_cmd_pkg::DEV_DONE
                       || cur.st == fw_cmd_pkg::DEV_DELAY);
  assign link.command_done_flag = cur.done;
  assign link.command_result_code = cur.result;
  assign link.reply = cur.reply;
  assign copy_start = cur.start;
  assign copy_way_out = cur.req.byte136;
  assign reset_pulse = cur.rst;
  assign reset_target = cur.target;
endmodule // fw_cmd_device

//--- logic/fw_cmd_host.sv
/*
  Host-side controller that issues copy-image and run-image requests.
  Assumes the user side pulses go only while ready is high.
*/
`timescale 1ns/10ps
`include "fw_cmd_consts.svh"
module fw_cmd_host (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // link to device
  fw_cmd_if.host link,
  // user side
  input wire logic go,
  input wire logic run_not_copy,
  input wire logic [7:0] way_or_target,
  input wire logic [15:0] delay_ms,
  output logic ready,
  output logic finished,
  output logic [7:0] result,
  output logic reply_updated
);
  typedef struct packed {
    fw_cmd_pkg::host_state_t st;
    fw_cmd_pkg::request_t req;
    logic fin;
    logic [7:0] res;
    logic upd;
  } host_t;

  host_t cur;
  host_t next_cur;
  fw_cmd_pkg::request_t build;

  // request assembly with check code
  always_comb begin
    build = '0;
    build.command_code = run_not_copy ? `CODE_RUN : `CODE_COPY;
    build.local_payload_length =
      run_not_copy ? `LPL_RUN : `LPL_COPY;
    build.byte136 = run_not_copy ? 8'h00 : way_or_target;
    build.byte137 = run_not_copy ? way_or_target : 8'h00;
    build.byte138_139 = run_not_copy ? delay_ms : 16'h0000;
    build.reply_length = 8'hff;
    build.reply_check_code = 8'hff;
    build.request_check_code = fw_cmd_pkg::check_code(build);
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    case (cur.st)
      fw_cmd_pkg::HOST_IDLE: begin
        if (go) begin
          next_cur.req = build;
          next_cur.fin = 1'b0;
          next_cur.st = fw_cmd_pkg::HOST_SEND;
        end
      end
      fw_cmd_pkg::HOST_SEND: begin
        next_cur.st = fw_cmd_pkg::HOST_WAIT;
      end
      fw_cmd_pkg::HOST_WAIT: begin
        // with zero delay the device pulses reset at the same edge this is taken in
        if (link.command_done_flag && !link.busy) begin
          next_cur.fin = 1'b1;
          next_cur.res = link.command_result_code;
          next_cur.upd = link.reply.reply_length
                         != cur.req.reply_length;
          next_cur.st = fw_cmd_pkg::HOST_IDLE;
        end
      end
      default: begin
        next_cur.st = fw_cmd_pkg::HOST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cur <= '0;
      cur.st <= fw_cmd_pkg::HOST_IDLE;
    end else if (clk_en) begin
      cur <= next_cur;
    end
  end

  assign link.req_valid = cur.st == fw_cmd_pkg::HOST_SEND;
  assign link.req = cur.req;
  assign ready = cur.st == fw_cmd_pkg::HOST_IDLE;
  assign finished = cur.fin;
  assign result = cur.res;
  assign reply_updated = cur.upd;
endmodule // fw_cmd_host

//--- tb/fw_cmd_props.sv
/*
  Checker for the link between host and device command engine.
  Assumes requests come only while clk_en is high, framed whole.
*/
`timescale 1ns/10ps
module fw_cmd_props (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // link signals
  input wire logic req_valid,
  input wire fw_cmd_pkg::request_t req,
  input wire logic busy,
  input wire logic command_done_flag,
  input wire logic [7:0] command_result_code,
  input wire fw_cmd_pkg::reply_t reply
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  // busy is low when the engine can accept and also in the reset delay, when requests are ignored
  sequence s_taken;
    req_valid && !busy;
  endsequence
  sequence s_bad_param;
    (req.command_code == 16'h0108 && req.byte136 != 8'hab
      && req.byte136 != 8'hba)
    || (req.command_code == 16'h0109 && req.byte137 > 8'h03);
  endsequence
  sequence s_good_run;
    req.command_code == 16'h0109 && req.byte136 == 8'h00
      && req.byte137 <= 8'h03;
  endsequence
  sequence s_done_rise;
    $rose(command_done_flag);
  endsequence

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_capture_code: assert property (
    s_taken |=> command_result_code == 8'h81)
    else $error("capture phase code missing");
  a_check_phase: assert property (
    command_result_code == 8'h81 |=> command_result_code == 8'h82)
    else $error("checking phase code missing");
  a_after_check: assert property (
    command_result_code == 8'h82 |=>
      (command_result_code == 8'h83 && !command_done_flag)
      || (command_done_flag && command_result_code inside {8'h42, 8'h45}))
    else $error("bad step after checking");
  a_done_codes: assert property (
    s_done_rise |-> command_result_code inside
      {8'h01, 8'h40, 8'h42, 8'h45})
    else $error("done with a non-final code");
  a_copy_reply: assert property (
    s_done_rise ##0 (command_result_code == 8'h01
      && req.command_code == 16'h0108) |-> reply.reply_length == 8'h06
      && reply.copy_way == req.byte136 && reply.copy_outcome == 8'h00)
    else $error("copy reply fields wrong");
  a_copy_fail: assert property (
    s_done_rise ##0 command_result_code == 8'h40
      |-> reply.copy_outcome == 8'h01)
    else $error("failed copy not reported");
  a_range_error: assert property (
    s_taken ##0 s_bad_param |-> ##3
      (command_done_flag && command_result_code == 8'h42))
    else $error("range error not reported");
  a_run_done: assert property (
    s_taken ##0 s_good_run |=> !command_done_flag [*3] ##1
      (command_done_flag && command_result_code == 8'h01
      && reply.reply_length == 8'h00))
    else $error("run command did not complete");
endmodule // fw_cmd_props

//--- tb/tb.sv
/*
  Testbench: host and device joined by one link, and a second device fed
  hand-made requests. Assumes 4 cycles stand for one millisecond.
*/
`timescale 1ns/10ps
module tb;
  localparam int UNIT = 4;
  logic mclk, reset_n, en, go, run_not_copy;
  logic [7:0] way_or_target, result, copy_way_out;
  logic [15:0] delay_ms;
  logic ready, finished, reply_updated, copy_start, copy_done;
  logic copy_fail, reset_pulse;
  logic [31:0] copy_count;
  logic [1:0] reset_target;
  int n_fail, checked;
  fw_cmd_if link();
  fw_cmd_if link_b();

  // ----------------------------------------
  // instances
  // ----------------------------------------
  fw_cmd_host fw_cmd_host_i (.mclk(mclk), .reset_n(reset_n), .clk_en(en),
    .link(link), .go(go), .run_not_copy(run_not_copy),
    .way_or_target(way_or_target), .delay_ms(delay_ms), .ready(ready),
    .finished(finished), .result(result), .reply_updated(reply_updated));
  fw_cmd_device #(.DELAY_UNIT(UNIT)) fw_cmd_device_i (.mclk(mclk),
    .reset_n(reset_n), .clk_en(en), .link(link), .copy_start(copy_start),
    .copy_way_out(copy_way_out), .copy_done(copy_done),
    .copy_fail(copy_fail), .copy_count(copy_count),
    .reset_pulse(reset_pulse), .reset_target(reset_target));
  // second engine sees three requests the host would never frame and one copy it would; copy support
  // is left out there, so a well-formed copy must be refused
  fw_cmd_device #(.COPY_SUPPORTED(1'b0), .DELAY_UNIT(UNIT))
    fw_cmd_device_b_i (.mclk(mclk),
    .reset_n(reset_n), .clk_en(en), .link(link_b), .copy_start(),
    .copy_way_out(), .copy_done(copy_done), .copy_fail(copy_fail),
    .copy_count(copy_count), .reset_pulse(), .reset_target());
  fw_cmd_props fw_cmd_props_i (.mclk(mclk), .reset_n(reset_n),
    .req_valid(link.req_valid), .req(link.req), .busy(link.busy),
    .command_done_flag(link.command_done_flag),
    .command_result_code(link.command_result_code), .reply(link.reply));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // bounded wait; a hang ends the run
  task automatic wait_fin();
    for (int k = 0; k < 400 && finished !== 1'b1; k++) @(negedge mclk);
    if (finished !== 1'b1) begin
      check(1'b0, "timeout");
      end_of_test();
    end
  endtask
  task automatic issue(input logic run, input logic [7:0] wt,
                       input logic [15:0] d);
    @(posedge mclk);
    go <= 1'b1;
    run_not_copy <= run;
    way_or_target <= wt;
    delay_ms <= d;
    @(posedge mclk);
    go <= 1'b0;
    @(negedge mclk);
  endtask
  // own sum over header and a four-byte payload
  function automatic logic [7:0] sum_code(input fw_cmd_pkg::request_t r);
    logic [7:0] s;
    s = r.command_code[15:8] + r.command_code[7:0]
      + r.extended_payload_length[15:8] + r.extended_payload_length[7:0]
      + r.local_payload_length + r.byte136 + r.byte137
      + r.byte138_139[15:8] + r.byte138_139[7:0];
    return ~s;
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_copy(input logic [7:0] way, input logic fail,
                        input logic [31:0] cnt);
    issue(1'b0, way, 16'h0000);
    for (int k = 0; k < 20 && copy_start !== 1'b1; k++) @(negedge mclk);
    if (copy_start !== 1'b1) begin
      check(1'b0, "copy start timeout");
      end_of_test();
    end
    check(copy_start === 1'b1 && copy_way_out === way
      && ready === 1'b0, "copy way");
    @(posedge mclk);
    copy_done <= 1'b1;
    copy_fail <= fail;
    copy_count <= cnt;
    @(posedge mclk);
    copy_done <= 1'b0;
    wait_fin();
    check(result === (fail ? 8'h40 : 8'h01), "copy status");
    check(link.reply.reply_length === 8'h06, "reply length");
    check(link.reply.bytes_copied === cnt, "byte count");
    check(link.reply.copy_way === way, "echoed way");
    check(link.reply.copy_outcome === {7'h00, fail}, "outcome");
    check(reply_updated === 1'b1, "reply not rewritten");
  endtask
  task automatic t_reject(input logic run, input logic [7:0] wt);
    issue(run, wt, 16'h0001);
    wait_fin();
    check(result === 8'h42, "range error expected");
  endtask
  // counts done-flag cycles before the image reset
  task automatic t_run(input logic [7:0] tgt, input logic [15:0] d);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    issue(1'b1, tgt, d);
    for (int k = 0; k < 300 && reset_pulse !== 1'b1; k++) begin
      if (link.busy === 1'b1) seen = 1'b1;
      if (seen && link.command_done_flag === 1'b1) n++;
      @(negedge mclk);
    end
    if (reset_pulse !== 1'b1) begin
      check(1'b0, "reset timeout");
      end_of_test();
    end
    check(n >= d * UNIT && n <= d * (UNIT + 1) + 1, "reset delay");
    check(reset_target === tgt[1:0], "reset target");
    wait_fin();
    check(result === 8'h01, "run status");
  endtask
  // a low enable must hold both ends; a go given meanwhile is lost
  task automatic t_freeze();
    @(posedge mclk);
    en <= 1'b0;
    issue(1'b1, 8'h00, 16'h0000);
    repeat (2) @(negedge mclk);
    check(finished === 1'b1 && ready === 1'b1 && link.req_valid === 1'b0
      && link.command_done_flag === 1'b1, "enable freeze");
    @(posedge mclk);
    en <= 1'b1;
  endtask
  task automatic t_inject(input fw_cmd_pkg::request_t r,
                          input logic [7:0] exp);
    @(posedge mclk);
    link_b.req <= r;
    link_b.req_valid <= 1'b1;
    @(posedge mclk);
    link_b.req_valid <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check(link_b.command_done_flag === 1'b1
      && link_b.command_result_code === exp, "injected request");
  endtask

  // clock at 50 MHz
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // main sequence
  initial begin
    fw_cmd_pkg::request_t r;
    {reset_n, go, run_not_copy, copy_done, copy_fail, n_fail} = '0;
    {way_or_target, delay_ms, copy_count, checked} = '0;
    en = 1'b1;
    link_b.req_valid = 1'b0;
    link_b.req = '0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    t_copy(8'hab, 1'b0, 32'h0001_2345);
    t_copy(8'hba, 1'b1, 32'h0000_0010);
    t_reject(1'b0, 8'h55);
    t_reject(1'b1, 8'h04);
    for (int t = 0; t < 4; t++) t_run(8'(t), 16'((t + 3) % 4));
    t_freeze();
    r = '{16'h0109, 16'h0000, 8'h04, 8'h00, 8'hff, 8'hff, 8'h00, 8'h02,
          16'h0005};
    r.request_check_code = sum_code(r) + 8'h01;
    t_inject(r, 8'h45);
    r.byte136 = 8'h01;
    r.request_check_code = sum_code(r);
    t_inject(r, 8'h42);
    r.byte136 = 8'h00;
    r.extended_payload_length = 16'h0001;
    r.request_check_code = sum_code(r);
    t_inject(r, 8'h42);
    r = '{16'h0108, 16'h0000, 8'h01, 8'h00, 8'hff, 8'hff, 8'hab, 8'h00,
          16'h0000};
    r.request_check_code = sum_code(r);
    t_inject(r, 8'h42);
    end_of_test();
  end
endmodule // tb
